// ===== rtl/dma_master_port_handshake.sv
// master-mode dma handshake for one data port of the coprocessor
// assumes pins resolved outside from data/parity out and enables;
// instantiate once per port (port a, port b)
// Summary of operation
// - acknowledge is asynchronous; two flip-flops synchronise it first
// - acknowledge sampled in t3; already low means next request at once
// - with write strobe disabled, acknowledge fall captures the data
// - second port uses an identical instance with its own signals
// - inbound: only request driven; ack, strobe, data, parity are inputs
// - request rises on clock edge, falls after acknowledge seen high
// - outbound data and parity driven while output enable is high
// - with output enable disabled, acknowledge gates the drive
// - outbound: request, data and parity driven; ack, enable inputs
// - request, acknowledge and strobe polarity are programmable
// - parity disabled keeps parity lines undriven always
`timescale 1ns/1ps
`include "dma_port_map.svh"
// one instance per port; instances share no state
module dma_master_port_handshake (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic dir_out_i,
  input wire logic strobe_en_i,
  input wire logic oe_en_i,
  input wire logic parity_en_i,
  input wire logic req_act_high_i,
  input wire logic ack_act_high_i,
  input wire logic strobe_act_high_i,
  output logic transfer_request_o,
  input wire logic transfer_acknowledge_i,
  input wire logic write_strobe_i,
  input wire logic output_enable_i,
  input wire logic [`DATA_W-1:0] data_bus_i,
  input wire logic [`PAR_W-1:0] parity_lines_i,
  output logic [`DATA_W-1:0] data_bus_o,
  output logic data_bus_oe_o,
  output logic [`PAR_W-1:0] parity_lines_o,
  output logic parity_lines_oe_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output dma_port_pkg::word_t rx_word_o,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire dma_port_pkg::word_t tx_word_i
);
  // pin inputs: two-stage synchronisers
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  dma_port_pkg::word_t pin_word_s1_ff;
  dma_port_pkg::word_t pin_word_s2_ff;
  logic strobe_d_ff;
  logic ack_d_ff;
  dma_port_pkg::hs_state_t state_ff;
  dma_port_pkg::hs_state_t nxt_state;
  logic req_ff;
  logic nxt_req;
  logic drive_ff;
  dma_port_pkg::word_t out_word_ff;
  logic data_oe_ff;
  logic par_oe_ff;
  logic rx_in_valid;
  logic rx_in_ready;
  logic rx_pend_ff;
  dma_port_pkg::word_t rx_pend_word_ff;

  function automatic logic pol(input logic raw, input logic act_high);
    pol = act_high ? raw : ~raw;
  endfunction

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {output_enable_i, write_strobe_i, transfer_acknowledge_i,
                   1'b0};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge mclk_i) begin
    pin_word_s1_ff <= '{par: parity_lines_i, data: data_bus_i};
    pin_word_s2_ff <= pin_word_s1_ff;
  end

  wire ack_s = pol(sync2_ff[1], ack_act_high_i);
  wire strobe_s = pol(sync2_ff[2], strobe_act_high_i);
  wire oe_s = sync2_ff[3];
  // disabled strobe: acknowledge stands in for it
  wire cap_strobe = strobe_en_i ? strobe_s : ack_s;
  // data captured when the strobe falls
  wire cap_fall = strobe_d_ff && !cap_strobe;
  // disabled output enable: acknowledge gates the drive
  wire gate_s = oe_en_i ? oe_s : ack_s;
  wire in_dir = !dir_out_i;
  wire word_ready = dir_out_i ? tx_valid_i : (rx_in_ready && !rx_pend_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    case (state_ff)
      dma_port_pkg::st_idle: begin
        // new request only once ack is low
        if (enable_i && word_ready && !ack_s) begin
          nxt_state = dma_port_pkg::st_req;
          nxt_req = 1'b1;
        end
      end
      dma_port_pkg::st_req: begin
        if (ack_s) begin
          nxt_state = dma_port_pkg::st_xfer;
          nxt_req = 1'b0;
        end
      end
      dma_port_pkg::st_xfer: begin
        if (!ack_s) nxt_state = dma_port_pkg::st_t3;
      end
      dma_port_pkg::st_t3: begin
        // ack already low at t3: next word at full rate
        if (!ack_s && enable_i && word_ready) begin
          nxt_state = dma_port_pkg::st_req;
          nxt_req = 1'b1;
        end else begin
          nxt_state = dma_port_pkg::st_idle;
        end
      end
      default: begin
        nxt_state = dma_port_pkg::st_idle;
        nxt_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= dma_port_pkg::st_idle;
      req_ff <= `REQ_RST;
      strobe_d_ff <= 1'b0;
      ack_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      strobe_d_ff <= cap_strobe;
      ack_d_ff <= ack_s;
    end
  end

  // request polarity applied at the flop so the pin is a flop output
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      transfer_request_o <= 1'b0;
    end else begin
      transfer_request_o <= pol(nxt_req, req_act_high_i);
    end
  end

  // outbound word: latched when the request goes out, once per cycle
  wire tx_take = dir_out_i && state_ff != dma_port_pkg::st_req &&
                 nxt_state == dma_port_pkg::st_req;
  assign tx_ready_o = tx_take;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_word_ff <= '0;
      drive_ff <= 1'b0;
      data_oe_ff <= 1'b0;
      par_oe_ff <= 1'b0;
    end else begin
      if (tx_take) out_word_ff <= tx_word_i;
      drive_ff <= dir_out_i && gate_s;
      // inbound direction never drives the pins
      data_oe_ff <= dir_out_i && gate_s;
      par_oe_ff <= dir_out_i && gate_s && parity_en_i;
    end
  end

  assign data_bus_o = out_word_ff.data;
  assign parity_lines_o = out_word_ff.par;
  assign data_bus_oe_o = data_oe_ff;
  assign parity_lines_oe_o = par_oe_ff;

  // inbound capture: one word per handshake into the buffer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_pend_ff <= 1'b0;
      rx_pend_word_ff <= '0;
    end else begin
      if (in_dir && cap_fall && state_ff != dma_port_pkg::st_idle) begin
        rx_pend_ff <= 1'b1;
        rx_pend_word_ff <= parity_en_i ? pin_word_s2_ff :
          '{par: '0, data: pin_word_s2_ff.data};
      end else if (rx_in_ready) begin
        rx_pend_ff <= 1'b0;
      end
    end
  end
  assign rx_in_valid = rx_pend_ff;

  word_buf2 u_rx_buf (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(rx_in_valid),
    .in_ready_o(rx_in_ready),
    .in_word_i(rx_pend_word_ff),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_word_o(rx_word_o)
  );
  // ack_d_ff kept for edge visibility of the handshake
  wire unused_ack = ack_d_ff & drive_ff;
endmodule

// ===== rtl/dma_port_map.svh
// constants for the master-mode dma port handshake: widths, timing
// assumes inclusion by bare name from the package and design files
`ifndef DMA_PORT_MAP_SVH
`define DMA_PORT_MAP_SVH
`define DATA_W 16
`define PAR_W 2
`define CLK_NS 100
`define ACK_MIN_NS 25
`define ACK_MIN_CYC ((`ACK_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define BUF_DEPTH 2
`define REQ_RST 1'b0
`endif

// ===== rtl/dma_port_pkg.sv
// types shared by the dma port handshake design files
// assumes dma_port_map.svh on the include path
`include "dma_port_map.svh"
package dma_port_pkg;
  typedef struct packed {
    logic [`PAR_W-1:0] par;
    logic [`DATA_W-1:0] data;
  } word_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_req = 2'b01,
    st_xfer = 2'b10,
    st_t3 = 2'b11
  } hs_state_t;
endpackage

// ===== rtl/word_buf2.sv
// two-entry word buffer with valid and ready on both sides
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`include "dma_port_map.svh"
module word_buf2 (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire dma_port_pkg::word_t in_word_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output dma_port_pkg::word_t out_word_o
);
  dma_port_pkg::word_t mem_ff [0:`BUF_DEPTH-1];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  wire push = in_valid_i && (cnt_ff != 2'h2);
  wire pop = out_ready_i && (cnt_ff != 2'h0);
  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_word_o = mem_ff[rd_ptr_ff];
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge mclk_i) begin
    if (push) mem_ff[wr_ptr_ff] <= in_word_i;
  end
endmodule

// ===== sim/dma_ctrl_model.sv
// controller model: answers each request with ack, strobe and enable
// assumes an active-high request and word_i held for the whole word
`timescale 1ns/1ps
module dma_ctrl_model (
  input wire logic mclk_i,
  input wire logic req_i,
  input wire logic [1:0] dly_i,
  input wire dma_port_pkg::word_t word_i,
  input wire dma_port_pkg::word_t pin_i,
  output logic ack_o,
  output logic strobe_o,
  output logic oe_o,
  output dma_port_pkg::word_t word_o,
  output dma_port_pkg::word_t got_o,
  output logic [7:0] n_done_o
);
  initial begin
    {ack_o, strobe_o, oe_o} = 3'h0;
    word_o = '1;
    got_o = '0;
    n_done_o = 8'h0;
    forever begin
      @(posedge mclk_i);
      if (req_i === 1'b1) begin
        repeat (dly_i) @(posedge mclk_i);
        ack_o <= 1'b1;
        @(posedge mclk_i);
        strobe_o <= 1'b1;
        oe_o <= 1'b1;
        word_o <= word_i;
        repeat (5) @(posedge mclk_i);
        got_o <= pin_i;
        strobe_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ack_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        oe_o <= 1'b0;
        // released lines show the inverse of the last word
        word_o <= ~word_i;
        n_done_o <= n_done_o + 8'h1;
      end
    end
  end
endmodule

// ===== sim/dma_master_port_handshake_bench.sv
// bench: words in and out of one port against the controller model
// assumes the design files and dma_ctrl_model compiled before it
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  num_errors++; $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module dma_master_port_handshake_bench;
  logic mclk_i = 0, nrst_i = 0, enable_i = 0, dir_out_i = 0, ack, stb, oe;
  logic strobe_en_i = 1, oe_en_i = 1, parity_en_i = 1, req_act_high_i = 1;
  logic ack_act_high_i = 1, strobe_act_high_i = 1;
  logic rx_ready_i = 0, tx_valid_i = 0, transfer_request_o, tx_ready_o;
  logic rx_valid_o, data_bus_oe_o, parity_lines_oe_o;
  logic [15:0] data_bus_o;
  logic [1:0] parity_lines_o, dly = 0;
  logic [7:0] n_done;
  dma_port_pkg::word_t tx_word_i = '0, m_w = '0, rx_word_o, m_pin, got, pin;
  int num_errors = 0, n_compared = 0;
  assign pin = {parity_lines_oe_o ? parity_lines_o : m_pin.par,
    data_bus_oe_o ? data_bus_o : m_pin.data};
  dma_master_port_handshake i_dma_master_port_handshake (.mclk_i, .nrst_i,
    .enable_i, .dir_out_i, .strobe_en_i, .oe_en_i, .parity_en_i,
    .req_act_high_i, .ack_act_high_i, .strobe_act_high_i,
    .transfer_request_o, .transfer_acknowledge_i(ack ~^ ack_act_high_i),
    .write_strobe_i(stb ~^ strobe_act_high_i),
    .output_enable_i(oe), .data_bus_i(pin.data), .parity_lines_i(pin.par),
    .data_bus_o, .data_bus_oe_o, .parity_lines_o, .parity_lines_oe_o,
    .rx_valid_o, .rx_ready_i, .rx_word_o, .tx_valid_i, .tx_ready_o,
    .tx_word_i);
  // model sees the request in active-high form, only while enabled
  dma_ctrl_model i_dma_ctrl_model (.mclk_i,
    .req_i((transfer_request_o ~^ req_act_high_i) & enable_i),
    .dly_i(dly), .word_i(m_w), .pin_i(pin), .ack_o(ack), .strobe_o(stb),
    .oe_o(oe), .word_o(m_pin), .got_o(got), .n_done_o(n_done));
  initial forever #50 mclk_i = ~mclk_i;
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bound(input logic ok);
    if (!ok) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task xfer(input logic [2:0] c, input dma_port_pkg::word_t w);
    logic [7:0] n0;
    int k;
    n0 = n_done;
    {dir_out_i, strobe_en_i, oe_en_i, parity_en_i} <= {c[2], c[1], c[1], c[0]};
    {dly, tx_word_i, tx_valid_i, enable_i} <= {c[1:0], w, c[2], 1'b1};
    m_w <= c[2] ? ~w : w;
    for (k = 0; k < 60 && ack !== 1'b1; k++) begin
      @(posedge mclk_i);
      if (tx_ready_o === 1'b1) tx_valid_i <= 1'b0;
    end
    bound(ack === 1'b1);
    {tx_valid_i, enable_i} <= 2'h0;
    for (k = 0; k < 60 && n_done == n0; k++) @(posedge mclk_i);
    bound(n_done != n0);
    // let the synchronised gate drop before settings change
    repeat (4) @(posedge mclk_i);
  endtask
  task pop(input dma_port_pkg::word_t e);
    int k;
    for (k = 0; k < 40 && rx_valid_o !== 1'b1; k++) @(posedge mclk_i);
    bound(rx_valid_o === 1'b1);
    `CHK("rx word", e, rx_word_o)
    rx_ready_i <= 1'b1;
    @(posedge mclk_i);
    rx_ready_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  initial begin
    int c;
    dma_port_pkg::word_t w;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    `CHK("request", 1'b0, transfer_request_o)
    req_act_high_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    `CHK("request", 1'b1, transfer_request_o)
    req_act_high_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (c = 0; c < 8; c++) begin
      w = {c[1:0], 16'h5a00 + 16'(c)};
      xfer(c[2:0], w);
      if (c[2]) `CHK("tx word", {c[0] ? w.par : ~w.par, w.data}, got)
      else pop({c[0] ? w.par : 2'h0, w.data});
    end
    {req_act_high_i, ack_act_high_i, strobe_act_high_i} <= 3'h0;
    repeat (3) @(posedge mclk_i);
    xfer(3'h3, 18'h2abcd);
    pop(18'h2abcd);
    {req_act_high_i, ack_act_high_i, strobe_act_high_i} <= 3'h7;
    repeat (3) @(posedge mclk_i);
    xfer(3'h3, 18'h11234);
    xfer(3'h3, 18'h02345);
    enable_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    `CHK("full", 1'b0, transfer_request_o)
    enable_i <= 1'b0;
    pop(18'h11234);
    pop(18'h02345);
    tally_and_finish();
  end
endmodule

// ===== sim/dma_master_port_handshake_checker.sv
// checker: request, drive-enable and parity rules at the port pins
// assumes one clock and the active-low reset of the port
`timescale 1ns/1ps
module dma_port_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic dir_out_i,
  input wire logic oe_en_i,
  input wire logic parity_en_i,
  input wire logic req_act_high_i,
  input wire logic ack_act_high_i,
  input wire logic transfer_request_o,
  input wire logic transfer_acknowledge_i,
  input wire logic output_enable_i,
  input wire logic data_bus_oe_o,
  input wire logic parity_lines_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire r = transfer_request_o ~^ req_act_high_i;
  wire a = transfer_acknowledge_i ~^ ack_act_high_i;
  wire g = oe_en_i ? output_enable_i : a;
  req_drop_a: assert property (r && a |-> ##[1:4] !r)
    else $error("request kept after ack");
  req_hold_a: assert property ((r && !a) [*3] |=> r)
    else $error("request dropped early");
  req_rearm_a: assert property (a [*4] |-> !$rose(r))
    else $error("request while ack high");
  req_idle_a: assert property
    (!enable_i && !r |=> !r || $changed(req_act_high_i))
    else $error("request while disabled");
  dir_in_a: assert property (!dir_out_i [*4] |-> !data_bus_oe_o)
    else $error("bus driven inbound");
  oe_off_a: assert property (!g [*4] |-> !data_bus_oe_o)
    else $error("bus driven without gate");
  oe_on_a: assert property ((dir_out_i && g) [*5] |-> data_bus_oe_o)
    else $error("bus not driven");
  par_off_a: assert property (!parity_en_i |-> !parity_lines_oe_o)
    else $error("parity driven while off");
  par_on_a: assert property (parity_en_i && $stable(parity_en_i) |->
    parity_lines_oe_o == data_bus_oe_o) else $error("parity drive differs");
endmodule
bind dma_master_port_handshake dma_port_checker i_dma_port_checker (
  .mclk_i, .nrst_i, .enable_i, .dir_out_i, .oe_en_i, .parity_en_i,
  .req_act_high_i, .ack_act_high_i, .transfer_request_o,
  .transfer_acknowledge_i, .output_enable_i, .data_bus_oe_o,
  .parity_lines_oe_o);
